// ===== bench/itmr_master.sv
/* Two-wire bus master model: serial clock and open-drain data level.
 * Assumes the caller resolves the data wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module itmr_master (
	output logic scl_out,
	output logic sda_out,
	input wire logic sda_in
);
	// Idle bus: clock stands high, data released
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Keeps every edge clear of the system clock's rising edges
	task automatic align;
		while ($time % 5 != 3) #1;
	endtask : align
	// Start, or repeated start when the clock is low
	task automatic start;
		align();
		#10 sda_out = 1'b1;
		#40 scl_out = 1'b1;
		#700 sda_out = 1'b0;
		#700 scl_out = 1'b0;
	endtask : start
	// Stop, then the bus-free time
	task automatic stop;
		align();
		#10 sda_out = 1'b0;
		#40 scl_out = 1'b1;
		#700 sda_out = 1'b1;
		#1500;
	endtask : stop
	// One bit: data moves only while the clock is low
	task automatic bitx(input logic b, output logic r);
		#20 sda_out = b;
		#60 scl_out = 1'b1;
		#75 r = sda_in;
		#5 scl_out = 1'b0;
	endtask : bitx
	// One byte, top bit first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack_out);
		align();
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ack_in, ack_out);
	endtask : xfer
endmodule : itmr_master
`default_nettype wire

// ===== bench/itmr_port_chk.sv
/* Pin-level checker of the two-wire slave port.
 * Assumes a bind onto the port, with the gate counts passed on. */
`timescale 1ns/1ps
`default_nettype none
module itmr_port_chk #(
	parameter int GATE_HOLD_CYC = 20,
	parameter int GATE_REL_CYC = 16
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic output_gate_pin_in,
	input wire logic [itmr_pkg::ITMR_CNT_W-1:0] elapsed_count_in,
	input wire logic [itmr_pkg::ITMR_OUT_W-1:0] setting_out,
	input wire logic count_clear_out,
	input wire logic osc_start_out,
	input wire logic bus_standby_out
);
	import itmr_pkg::*;
	int lo_cnt_r; // Gate low run length
	int hi_cnt_r; // Gate high run length
	// Run lengths saturate, so a long run never wraps
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lo_cnt_r <= 0;
			hi_cnt_r <= 0;
		end else begin
			lo_cnt_r <= output_gate_pin_in ? 0 : lo_cnt_r + int'(lo_cnt_r < 99999);
			hi_cnt_r <= output_gate_pin_in ? hi_cnt_r + int'(hi_cnt_r < 99999) : 0;
		end
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	// Clear pulse lasts one cycle, inside a frame
	sequence clr_once_s;
		!bus_standby_out ##1 !count_clear_out;
	endsequence
	// Both lines high, as after a stop
	sequence bus_up_s;
		scl_in && sda_in;
	endsequence
	sda_low_a: assert property (sda_oe_out |-> !sda_out && !sda_in)
		else $error("driven data line not low");
	oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in && $past(scl_in))
		else $error("data drive moved off a clock fall");
	idle_quiet_a: assert property (bus_standby_out |-> !sda_oe_out)
		else $error("idle port drives data");
	idle_start_a: assert property ($fell(bus_standby_out) |-> scl_in && !sda_in)
		else $error("frame opened without a start");
	idle_stop_a: assert property ($rose(bus_standby_out) |-> bus_up_s)
		else $error("idle entered without a stop");
	set_busy_a: assert property ($changed(setting_out) |-> !bus_standby_out)
		else $error("setting moved outside a frame");
	clr_once_a: assert property (count_clear_out |-> clr_once_s)
		else $error("bad clear pulse");
	osc_force_a: assert property (lo_cnt_r > GATE_HOLD_CYC + 5 |-> osc_start_out)
		else $error("long gate low left start off");
	osc_free_a: assert property (hi_cnt_r > GATE_REL_CYC + 5 |-> !osc_start_out)
		else $error("start held after gate high");
	osc_hold_a: assert property ($rose(osc_start_out) |-> lo_cnt_r >= GATE_HOLD_CYC)
		else $error("start forced too early");
endmodule : itmr_port_chk
`default_nettype wire

// ===== bench/test_interval_timer_i2c_slave_port.sv
/* Self-checking bench of the two-wire slave port with a master model.
 * Assumes shortened gate counts; expectations come from a bench model. */
`timescale 1ns/1ps
`default_nettype none
module test_interval_timer_i2c_slave_port;
	import itmr_pkg::*;
	localparam int HOLD = 20; // Shortened gate hold count
	localparam int REL = 16; // Shortened gate release count
	logic clock_in, rst_n_in, gate, scl, sda_m, oe, sda_o, clr, osc, idle, a;
	logic [23:0] cnt; // Elapsed counter fed in
	logic [9:0] set_o;
	logic [15:0] set_m; // Model of the setting register
	logic [7:0] q, b3, b4;
	wire logic sda = sda_m & ~(oe & ~sda_o); // Pull-up unless someone pulls low
	int error_cnt, samples_checked, cyc, clr_n, clr_exp;
	integer seed;
	itmr_master m (.scl_out(scl), .sda_out(sda_m), .sda_in(sda));
	itmr_port #(.GATE_HOLD_CYC(HOLD), .GATE_REL_CYC(REL)) uut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(oe), .output_gate_pin_in(gate), .elapsed_count_in(cnt),
		.setting_out(set_o), .count_clear_out(clr), .osc_start_out(osc),
		.bus_standby_out(idle));
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	// Clear pulses seen, and the hang limit
	always @(posedge clock_in) begin
		clr_n <= clr_n + int'(clr === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_f(input logic got, input logic exp);
		cmp({15'h0000, got}, {15'h0000, exp});
	endtask : cmp_f
	// Write pointer byte and both setting bytes; model follows only when addressed
	task automatic wr(input logic [7:0] adr, input logic [7:0] d3, input logic [7:0] d4);
		m.start();
		m.xfer(adr, 1'b1, q, a);
		cmp_f(a, adr != 8'h64);
		for (int k = 0; k < 3; k++) begin
			m.xfer(k == 0 ? 8'h81 : k == 1 ? d3 : d4, 1'b1, q, a);
			cmp_f(a, adr != 8'h64);
		end
		if (adr == 8'h64) begin
			set_m = {d3, d4[7:5], 2'b00, d4[2:0]};
			clr_exp += int'(d4[2:0] == 3'b010);
		end
		m.stop();
		cmp({6'h00, set_o}, {6'h00, set_m[15:6]});
		cmp(clr_n[15:0], clr_exp[15:0]);
	endtask : wr
	// Read n bytes, after a pointer write and repeated start if asked
	task automatic rd(input logic dummy, input int n);
		logic [7:0] e;
		logic [23:0] c;
		c = cnt;
		m.start();
		if (dummy) begin
			m.xfer(8'h64, 1'b1, q, a);
			m.xfer(8'h01, 1'b1, q, a);
			m.start();
		end
		m.xfer(8'h65, 1'b1, q, a);
		cmp_f(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			e = 8'hFF;
			if (dummy && gate && i < 2) e = set_m[15 - 8 * i -: 8];
			else if (!(dummy && gate) && i < 3) e = c[23 - 8 * i -: 8];
			m.xfer(8'hFF, i == n - 1, q, a);
			cmp({8'h00, q}, {8'h00, e});
			if (i == 0) begin
				// Counter moves mid-frame; later bytes must keep the frozen value
				@(posedge clock_in);
				cnt <= ~c;
			end
		end
		m.stop();
	endtask : rd
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		seed = 39;
		rst_n_in = 1'b0;
		gate = 1'b1;
		cnt = 24'h000000;
		set_m = 16'h0000;
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (4) @(negedge clock_in);
		cmp({6'h00, set_o}, 16'h0000);
		cmp_f(idle, 1'b1);
		cmp_f(osc, 1'b0);
		rd(1'b1, 3);
		wr(8'h66, 8'hA5, 8'h5A);
		// Every clear code once, random setting bits
		for (int k = 0; k < 8; k++) begin
			b3 = 8'($random(seed));
			b4 = {3'($random(seed)), 2'b11, k[2:0]};
			wr(8'h64, b3, b4);
		end
		@(posedge clock_in);
		cnt <= 24'($random(seed));
		rd(1'b1, 4);
		// Pointer write closed by a stop loses the pointer
		m.start();
		m.xfer(8'h64, 1'b1, q, a);
		m.xfer(8'h01, 1'b1, q, a);
		m.stop();
		rd(1'b0, 5);
		@(posedge clock_in);
		gate <= 1'b0;
		@(posedge clock_in);
		rd(1'b1, 3);
		cmp_f(osc, 1'b1);
		@(posedge clock_in);
		gate <= 1'b1;
		cnt <= 24'($random(seed)) & 24'h7FFFFF;
		repeat (REL + 8) @(negedge clock_in);
		cmp_f(osc, 1'b0);
		// Start hidden under a driven low bit, then nine released clocks
		m.start();
		m.xfer(8'h65, 1'b1, q, a);
		m.start();
		repeat (9) m.bitx(1'b1, a);
		m.stop();
		cmp_f(idle, 1'b1);
		rd(1'b0, 3);
		finish_test();
	end
endmodule : test_interval_timer_i2c_slave_port
bind itmr_port itmr_port_chk #(.GATE_HOLD_CYC(GATE_HOLD_CYC), .GATE_REL_CYC(GATE_REL_CYC)) chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_out(sda_oe_out), .output_gate_pin_in(output_gate_pin_in),
	.elapsed_count_in(elapsed_count_in), .setting_out(setting_out),
	.count_clear_out(count_clear_out), .osc_start_out(osc_start_out),
	.bus_standby_out(bus_standby_out));
`default_nettype wire

// ===== src/itmr_pkg.sv
/*
 * Shared constants and types of the interval timer two-wire slave port.
 * Assumes a 20 MHz system clock and a serial clock that only runs inside frames.
 */
package itmr_pkg;
	// System clock rate and the gate-pin hold time, in their own units
	localparam int ITMR_CLK_HZ = 20_000_000;
	localparam int ITMR_GATE_HOLD_MS = 500;
	localparam int ITMR_GATE_REL_MS = 500;
	// Cycles per millisecond first, so the product stays inside 32 bits
	localparam int ITMR_GATE_HOLD_CYC = (ITMR_GATE_HOLD_MS * (ITMR_CLK_HZ / 1000));
	localparam int ITMR_GATE_REL_CYC = (ITMR_GATE_REL_MS * (ITMR_CLK_HZ / 1000));

	// Bus addressing and byte framing
	localparam logic [6:0] ITMR_SLAVE_ADDR = 7'h32;
	localparam logic [3:0] ITMR_LAST_BIT = 4'h7;
	localparam logic [3:0] ITMR_ACK_SLOT = 4'h8;
	localparam logic [7:0] ITMR_FILL_BYTE = 8'hFF;
	localparam int ITMR_PTR_POS = 7;
	localparam logic ITMR_PTR_SETTING = 1'b0;
	localparam logic ITMR_PTR_COUNT = 1'b1;

	// Byte positions after the address byte
	localparam logic [2:0] ITMR_BYTE_FIRST = 3'h0;
	localparam logic [2:0] ITMR_BYTE_SECOND = 3'h1;
	localparam logic [2:0] ITMR_BYTE_THIRD = 3'h2;
	localparam logic [2:0] ITMR_BYTE_MAX = 3'h7;

	// Setting register layout
	localparam int ITMR_SET_W = 16;
	localparam int ITMR_OUT_W = 10;
	localparam int ITMR_OUT_LSB = 6;
	localparam logic [ITMR_SET_W-1:0] ITMR_SET_RESET = 16'h0000;
	localparam logic [7:0] ITMR_LOW_KEEP = 8'hE7;
	localparam logic [2:0] ITMR_CLEAR_CODE = 3'h2;
	localparam int ITMR_CNT_W = 24;

	// Link-side transfer phases
	typedef enum logic [2:0] {
		ITMR_L_ADDR,
		ITMR_L_WDATA,
		ITMR_L_RSTART,
		ITMR_L_RDATA,
		ITMR_L_SKIP
	} itmr_link_e;
endpackage : itmr_pkg

// ===== src/itmr_port.sv
/*
 * Two-wire slave port of the interval timer: framing, acknowledge, pointer,
 * setting register, count-clear command and the gate-pin oscillator override.
 * Assumes the elapsed counter and the waveform generator sit outside and run
 * on clock_in; scl_in clocks the link logic and stands still between frames.
 */
// Contract
// RULE_01: Data changes only while clock is low
// RULE_02: Pull data low through the ninth clock
// RULE_03: First byte is address 0110010 plus direction
// RULE_04: Direction 0 writes setting, 1 reads
// RULE_05: Bytes most significant first, each received acknowledged
// RULE_06: Master leaves last read byte unacknowledged
// RULE_07: Start in place of stop is repeated start
// RULE_08: Counter bytes are transfer bytes two to four
// RULE_09: All ones after three counter bytes
// RULE_10: Second write byte ends in test bit one
// RULE_11: Setting from third byte and fourth top bits
// RULE_12: Code 010 clears counter, others leave it
// RULE_13: Master writes setting in whole byte pairs
// RULE_14: Pointer zero, repeated start, then read setting
// RULE_15: Gate pin low returns counter instead
// RULE_16: All ones after two setting bytes
// RULE_17: Stop clears pointer, later read gives counter
// RULE_18: Only stop returns the interface to idle
// RULE_19: Ignore start or stop while driving low
// RULE_20: Master frees stuck bus with nine clocks
// RULE_21: Gate low 500 ms forces oscillator start
// RULE_22: Counter bytes come from one consistent value
// RULE_23: Setting value is upper ten register bits
// RULE_24: Stop ends access and enters standby
// RULE_25: No acknowledge and ignore on address mismatch
// RULE_26: Release data line after next falling edge
`timescale 1ns/1ps
`default_nettype none
module itmr_port #(
	parameter int GATE_HOLD_CYC = itmr_pkg::ITMR_GATE_HOLD_CYC,
	parameter int GATE_REL_CYC = itmr_pkg::ITMR_GATE_REL_CYC
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic output_gate_pin_in,
	input wire logic [itmr_pkg::ITMR_CNT_W-1:0] elapsed_count_in,
	output logic [itmr_pkg::ITMR_OUT_W-1:0] setting_out,
	output logic count_clear_out,
	output logic osc_start_out,
	output logic bus_standby_out
);
	import itmr_pkg::*;

	// Gate counter wide enough for the longer of the two waits
	localparam int GMAX = (GATE_HOLD_CYC > GATE_REL_CYC) ? GATE_HOLD_CYC : GATE_REL_CYC;
	localparam int GCW = $clog2(GMAX + 1);

	// Synchroniser lane positions
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_GATE = 2;
	localparam int SY_WR = 3;
	localparam int SY_CLR = 4;
	localparam int SY_W = 5;

	// System-domain state
	typedef struct packed {
		logic link_clear; // Holds the link logic in reset between frames
		logic scl_p1; // Delayed copies for start/stop detection
		logic scl_p2;
		logic sda_p1;
		logic sda_p2;
		logic gate_p1; // Previous gate level, restarts the timer
		logic [ITMR_CNT_W-1:0] snap_cnt; // Counter frozen for a frame
		logic snap_gate; // Gate level frozen for a frame
		logic wr_seen; // Last seen write toggle
		logic clr_seen; // Last seen clear toggle
		logic [ITMR_OUT_W-1:0] setting; // Setting value for the waveform logic
		logic clr_pulse; // One-cycle counter clear
		logic osc_start; // Oscillator start override
		logic [GCW-1:0] gate_cnt; // Cycles since the last gate change
	} itmr_sys_s;

	// Link-domain state cleared by stop
	typedef struct packed {
		itmr_link_e st; // Transfer phase
		logic [3:0] bit_cnt; // Bits done in the byte, 8 marks the ack slot
		logic [7:0] shreg; // Incoming byte
		logic [7:0] tx; // Outgoing bits still to send
		logic [2:0] byte_idx; // Byte count after the address
		logic ptr; // Register pointer
		logic sda_oe; // Data line pulled low
		logic sda_level; // Level driven when enabled, always low
	} itmr_link_s;

	// Link-domain state that survives stop
	typedef struct packed {
		logic [ITMR_SET_W-1:0] setting; // Whole setting register
		logic wr_tgl; // Flips on each setting byte
		logic clr_tgl; // Flips on each clear command
	} itmr_keep_s;

	itmr_sys_s sys_r, sys_nxt;
	itmr_link_s lk_r, lk_nxt;
	itmr_keep_s kp_r, kp_nxt;
	logic rise_sda_r; // Data level at the last rising clock edge
	logic link_rst_n; // Reset of the frame logic
	logic [SY_W-1:0] sync_q;

	// Read byte selection, shared by first and following bytes
	function automatic logic [7:0] itmr_read_byte(
		input logic ptr,
		input logic gate,
		input logic [2:0] idx,
		input logic [ITMR_SET_W-1:0] setting,
		input logic [ITMR_CNT_W-1:0] cnt
	);
		logic [7:0] b;
		b = ITMR_FILL_BYTE;
		if (ptr == ITMR_PTR_SETTING && gate) begin // [RULE_15]
			if (idx == ITMR_BYTE_FIRST) begin
				b = setting[15:8];
			end else if (idx == ITMR_BYTE_SECOND) begin
				b = setting[7:0];
			end // Later bytes stay all ones [RULE_16]
		end else begin
			if (idx == ITMR_BYTE_FIRST) begin // [RULE_08]
				b = cnt[23:16];
			end else if (idx == ITMR_BYTE_SECOND) begin
				b = cnt[15:8];
			end else if (idx == ITMR_BYTE_THIRD) begin
				b = cnt[7:0];
			end // Later bytes stay all ones [RULE_09]
		end
		return b;
	endfunction : itmr_read_byte

	// Pins and link toggles into the system domain
	itmr_sync #(
		.W(SY_W)
	) u_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.d_in({kp_r.clr_tgl, kp_r.wr_tgl, output_gate_pin_in, sda_in, scl_in}),
		.q_out(sync_q)
	);

	// System side: start/stop watch, snapshot, hand-over of writes, gate timer
	always_comb begin
		logic scl_high;
		logic sda_rose;
		logic sda_fell;
		logic gate_s;
		// Clock high on both sides of the data edge, so skew cannot fake one
		scl_high = sync_q[SY_SCL] & sys_r.scl_p1 & sys_r.scl_p2;
		sda_rose = sys_r.sda_p1 & ~sys_r.sda_p2;
		sda_fell = ~sys_r.sda_p1 & sys_r.sda_p2;
		gate_s = sync_q[SY_GATE];
		sys_nxt = sys_r;
		sys_nxt.scl_p1 = sync_q[SY_SCL];
		sys_nxt.scl_p2 = sys_r.scl_p1;
		sys_nxt.sda_p1 = sync_q[SY_SDA];
		sys_nxt.sda_p2 = sys_r.sda_p1;
		sys_nxt.gate_p1 = gate_s;
		// Between frames the snapshot follows the live values
		if (sys_r.link_clear) begin
			sys_nxt.snap_cnt = elapsed_count_in;
			sys_nxt.snap_gate = gate_s;
		end
		if (scl_high && sda_rose) begin
			// Stop: frame logic back to idle and standby [RULE_18] [RULE_24]
			sys_nxt.link_clear = 1'b1; // [RULE_17]
		end else if (scl_high && sda_fell) begin
			// Start or repeated start freezes one counter value [RULE_22]
			sys_nxt.link_clear = 1'b0;
			sys_nxt.snap_cnt = elapsed_count_in;
			sys_nxt.snap_gate = gate_s;
		end
		// Setting bytes apply one at a time as they land [RULE_13]
		if (sync_q[SY_WR] != sys_r.wr_seen) begin
			sys_nxt.wr_seen = sync_q[SY_WR];
			sys_nxt.setting = kp_r.setting[ITMR_SET_W-1:ITMR_OUT_LSB]; // [RULE_23]
		end
		// Clear command becomes a single-cycle pulse [RULE_12]
		sys_nxt.clr_pulse = (sync_q[SY_CLR] != sys_r.clr_seen);
		sys_nxt.clr_seen = sync_q[SY_CLR];
		// Gate timer restarts on every level change
		if (gate_s != sys_r.gate_p1) begin
			sys_nxt.gate_cnt = '0;
		end else if (sys_r.gate_cnt != GCW'(GMAX)) begin
			sys_nxt.gate_cnt = sys_r.gate_cnt + 1'b1;
		end
		// Low long enough forces start, high long enough drops it [RULE_21]
		if (!gate_s && sys_r.gate_cnt == GCW'(GATE_HOLD_CYC - 1)) begin
			sys_nxt.osc_start = 1'b1;
		end else if (gate_s && sys_r.gate_cnt == GCW'(GATE_REL_CYC - 1)) begin
			sys_nxt.osc_start = 1'b0;
		end
	end

	// System state register
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sys_r <= '{link_clear: 1'b1, scl_p1: 1'b0, scl_p2: 1'b0, sda_p1: 1'b0,
				sda_p2: 1'b0, gate_p1: 1'b0, snap_cnt: '0, snap_gate: 1'b0,
				wr_seen: 1'b0, clr_seen: 1'b0, setting: '0, clr_pulse: 1'b0,
				osc_start: 1'b0, gate_cnt: '0};
		end else begin
			sys_r <= sys_nxt;
		end
	end

	// Stop or system reset clears the frame logic; the gate pin plays no part
	assign link_rst_n = rst_n_in & ~sys_r.link_clear; // [RULE_18]

	// Data sampled while the clock is high [RULE_01]
	always_ff @(posedge scl_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			// Reads high so the falling edge after a start is seen as one
			rise_sda_r <= 1'b1;
		end else begin
			rise_sda_r <= sda_in;
		end
	end

	// Link side: every decision is made on the falling clock edge
	always_comb begin
		logic start;
		logic bit_in;
		logic [7:0] byte_in;
		logic [7:0] rb;
		lk_nxt = lk_r;
		kp_nxt = kp_r;
		bit_in = rise_sda_r;
		byte_in = {lk_r.shreg[6:0], bit_in}; // Top bit first [RULE_05]
		rb = ITMR_FILL_BYTE;
		// High at the rising edge, low now: a start. Never seen while we hold low
		start = rise_sda_r & ~sda_in; // [RULE_01] [RULE_19]
		if (start) begin
			// Also the repeated start, no trip through idle [RULE_07]
			lk_nxt.st = ITMR_L_ADDR;
			lk_nxt.bit_cnt = '0;
			lk_nxt.sda_oe = 1'b0;
		end else begin
			case (lk_r.st)
				ITMR_L_ADDR: begin
					if (lk_r.bit_cnt == ITMR_LAST_BIT) begin
						lk_nxt.byte_idx = ITMR_BYTE_FIRST;
						if (byte_in[7:1] == ITMR_SLAVE_ADDR) begin // [RULE_03]
							lk_nxt.sda_oe = 1'b1; // [RULE_02]
							lk_nxt.bit_cnt = ITMR_ACK_SLOT;
							// Direction fixes the rest of the frame [RULE_04]
							lk_nxt.st = byte_in[0] ? ITMR_L_RSTART : ITMR_L_WDATA;
						end else begin
							lk_nxt.st = ITMR_L_SKIP; // Line left free [RULE_25]
						end
					end else begin
						lk_nxt.shreg = byte_in;
						lk_nxt.bit_cnt = lk_r.bit_cnt + 1'b1;
					end
				end
				ITMR_L_WDATA: begin
					if (lk_r.bit_cnt == ITMR_ACK_SLOT) begin
						// Acknowledge ends at this falling edge [RULE_26]
						lk_nxt.sda_oe = 1'b0;
						lk_nxt.bit_cnt = '0;
					end else if (lk_r.bit_cnt == ITMR_LAST_BIT) begin
						lk_nxt.sda_oe = 1'b1; // Every byte acknowledged [RULE_02] [RULE_05]
						lk_nxt.bit_cnt = ITMR_ACK_SLOT;
						if (lk_r.byte_idx != ITMR_BYTE_MAX) begin
							lk_nxt.byte_idx = lk_r.byte_idx + 1'b1;
						end
						if (lk_r.byte_idx == ITMR_BYTE_FIRST) begin
							// Pointer bit; the test bit is not checked [RULE_10] [RULE_14]
							lk_nxt.ptr = byte_in[ITMR_PTR_POS];
						end else if (lk_r.byte_idx == ITMR_BYTE_SECOND) begin
							kp_nxt.setting[15:8] = byte_in; // [RULE_11]
							kp_nxt.wr_tgl = ~kp_r.wr_tgl;
						end else if (lk_r.byte_idx == ITMR_BYTE_THIRD) begin
							// Filler bits dropped, code kept for read-back [RULE_11]
							kp_nxt.setting[7:0] = byte_in & ITMR_LOW_KEEP;
							kp_nxt.wr_tgl = ~kp_r.wr_tgl;
							if (byte_in[2:0] == ITMR_CLEAR_CODE) begin // [RULE_12]
								kp_nxt.clr_tgl = ~kp_r.clr_tgl;
							end
						end
					end else begin
						lk_nxt.shreg = byte_in;
						lk_nxt.bit_cnt = lk_r.bit_cnt + 1'b1;
					end
				end
				ITMR_L_RSTART: begin
					// Address ack over: put out the first read byte's top bit
					rb = itmr_read_byte(lk_r.ptr, sys_r.snap_gate, ITMR_BYTE_FIRST,
						kp_r.setting, sys_r.snap_cnt);
					lk_nxt.sda_oe = ~rb[7]; // [RULE_26]
					lk_nxt.tx = {rb[6:0], 1'b1};
					lk_nxt.byte_idx = ITMR_BYTE_SECOND;
					lk_nxt.bit_cnt = '0;
					lk_nxt.st = ITMR_L_RDATA;
				end
				ITMR_L_RDATA: begin
					if (lk_r.bit_cnt == ITMR_ACK_SLOT) begin
						if (bit_in) begin
							// No acknowledge: read over, wait for stop [RULE_06]
							lk_nxt.sda_oe = 1'b0;
							lk_nxt.st = ITMR_L_SKIP;
						end else begin
							rb = itmr_read_byte(lk_r.ptr, sys_r.snap_gate, lk_r.byte_idx,
								kp_r.setting, sys_r.snap_cnt);
							lk_nxt.sda_oe = ~rb[7]; // [RULE_05]
							lk_nxt.tx = {rb[6:0], 1'b1};
							lk_nxt.bit_cnt = '0;
							if (lk_r.byte_idx != ITMR_BYTE_MAX) begin
								lk_nxt.byte_idx = lk_r.byte_idx + 1'b1;
							end
						end
					end else if (lk_r.bit_cnt == ITMR_LAST_BIT) begin
						// Free the line for the master's acknowledge [RULE_26]
						lk_nxt.sda_oe = 1'b0;
						lk_nxt.bit_cnt = ITMR_ACK_SLOT;
					end else begin
						lk_nxt.sda_oe = ~lk_r.tx[7];
						lk_nxt.tx = {lk_r.tx[6:0], 1'b1};
						lk_nxt.bit_cnt = lk_r.bit_cnt + 1'b1;
					end
				end
				ITMR_L_SKIP: begin
					// Ignore the rest; only a start or stop leaves this
					lk_nxt.sda_oe = 1'b0;
				end
				default: begin
					lk_nxt.st = ITMR_L_SKIP;
					lk_nxt.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Frame state, cleared by stop so the pointer returns to the counter
	always_ff @(negedge scl_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lk_r <= '{st: ITMR_L_ADDR, bit_cnt: 4'h0, shreg: 8'h00, tx: 8'hFF,
				byte_idx: 3'h0, ptr: ITMR_PTR_COUNT, sda_oe: 1'b0,
				sda_level: 1'b0}; // [RULE_17]
		end else begin
			lk_r <= lk_nxt;
		end
	end

	// Setting register keeps its value across frames
	always_ff @(negedge scl_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			kp_r <= '{setting: ITMR_SET_RESET, wr_tgl: 1'b0, clr_tgl: 1'b0};
		end else begin
			kp_r <= kp_nxt;
		end
	end

	// Outputs straight from flops
	assign sda_out = lk_r.sda_level;
	assign sda_oe_out = lk_r.sda_oe;
	assign setting_out = sys_r.setting;
	assign count_clear_out = sys_r.clr_pulse;
	assign osc_start_out = sys_r.osc_start;
	assign bus_standby_out = sys_r.link_clear; // [RULE_24]
endmodule : itmr_port
`default_nettype wire

// ===== src/itmr_sync.sv
/*
 * Two-flop level synchroniser into the system clock domain, one stage pair per bit.
 * Assumes each input bit is a level or a toggle that holds for several clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module itmr_sync #(
	parameter int W = 1
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	// One independent flop pair per bit
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic meta_r; // First stage, read only by the second
			always_ff @(posedge clock_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_r <= 1'b0;
					q_out[gi] <= 1'b0;
				end else begin
					meta_r <= d_in[gi];
					q_out[gi] <= meta_r;
				end
			end
		end
	endgenerate
endmodule : itmr_sync
`default_nettype wire
